/* common/lrx_pkg.sv */
// Package for the serial LAN frame receive link: register map, types, check code generator
package lrx_pkg;

	// ------------------------------------------------------------
	// Register map (byte offsets) and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] LRX_OFS_CTRL = 8'h00;
	localparam logic [7:0] LRX_OFS_ADDR_LO = 8'h04;
	localparam logic [7:0] LRX_OFS_ADDR_HI = 8'h08;
	localparam logic [7:0] LRX_OFS_STATUS = 8'h0C;
	localparam logic [7:0] LRX_OFS_LENGTH = 8'h10;
	localparam logic [7:0] LRX_OFS_COUNT = 8'h14;
	localparam logic [2:0] LRX_CTRL_RESET = 3'h5;
	localparam logic [47:0] LRX_ADDR_RESET = 48'h0000_0000_0000;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int LRX_CTRL_ENABLE = 0;
	localparam int LRX_CTRL_PROMISC = 1;
	localparam int LRX_CTRL_BCAST = 2;
	localparam int LRX_STAT_CODE_LSB = 0;
	localparam int LRX_STAT_TRAIL_LSB = 2;
	localparam int LRX_STAT_ACTIVE = 8;
	localparam int LRX_STAT_CARRIER = 9;
	localparam int LRX_STAT_CONTENTION = 10;
	localparam int LRX_CNT_FRAG_LSB = 16;

	// ------------------------------------------------------------
	// Frame constants
	// ------------------------------------------------------------
	localparam int LRX_LEN_W = 16;
	localparam logic [12:0] LRX_DEST_LAST_OCTET = 13'h0005;
	localparam logic [7:0] LRX_BCAST_OCTET = 8'hFF;
	localparam int LRX_BIT_TIME_NS = 100;
	localparam int LRX_HCLK_NS = 8;
	localparam int LRX_CYCLES_PER_BIT = LRX_BIT_TIME_NS / LRX_HCLK_NS;
	localparam logic [31:0] LRX_CRC_POLY = 32'hEDB8_8320;
	localparam logic [31:0] LRX_CRC_INIT = 32'hFFFF_FFFF;
	localparam logic [31:0] LRX_CRC_RESIDUE = 32'hDEBB_20E3;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		LRX_ST_INIT = 4'b0001,
		LRX_ST_ARM = 4'b0010,
		LRX_ST_RECV = 4'b0100,
		LRX_ST_LEN = 4'b1000
	} lrx_state_t;

	typedef enum logic [1:0] {
		LRX_STATUS_GOOD = 2'b00,
		LRX_STATUS_CHECKSUM_FAIL = 2'b01,
		LRX_STATUS_MISALIGNED = 2'b10
	} lrx_status_t;

	typedef struct packed {
		logic rx_clk;
		logic rx_data;
		logic carrier_present;
		logic contention_flag;
	} lrx_phy_rx_t;

	typedef struct packed {
		logic hdr_valid;
		logic [47:0] dest;
		logic octet_valid;
		logic [7:0] octet;
		logic done;
		logic cancel;
		lrx_status_t status;
		logic [2:0] trailing;
		logic [LRX_LEN_W-1:0] length;
	} lrx_client_rx_t;

	// Serial check code generator, LSB-first reflected form
	function automatic logic [31:0] lrx_crc_step(input logic [31:0] c, input logic b);
		lrx_crc_step = (c[0] ^ b) ? ((c >> 1) ^ LRX_CRC_POLY) : (c >> 1);
	endfunction

endpackage

/* verilog/lrx_frame_receive_link.sv */
// Frame receive link with AHB-Lite register slave and client stream
//
// The address map and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ns
module lrx_frame_receive_link
	import lrx_pkg::*;
#(
	parameter int SLOT_BITS = 512
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Physical channel receive pins
	input wire lrx_phy_rx_t phy_in,
	// Client receive stream
	output lrx_client_rx_t client_rx
);

	// ------------------------------------------------------------
	// Pin synchronisers and bit clock edge
	// ------------------------------------------------------------
	lrx_phy_rx_t phy_s1_r;
	lrx_phy_rx_t phy_s2_r;
	logic clk_s3_r;
	logic bit_tick;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phy_s1_r <= '0;
			phy_s2_r <= '0;
			clk_s3_r <= 1'b0;
		end else begin
			phy_s1_r <= phy_in;
			phy_s2_r <= phy_s1_r;
			clk_s3_r <= phy_s2_r.rx_clk;
		end
	end

	// Rising edge of the recovered bit clock paces every bit, while each clock phase lasts longer than one hclk period
	assign bit_tick = phy_s2_r.rx_clk & ~clk_s3_r;

	// ------------------------------------------------------------
	// Registers over AHB-Lite
	// ------------------------------------------------------------
	logic [2:0] ctrl_r;
	logic [47:0] station_r;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic [31:0] hrdata_r;
	logic [31:0] rd_mux;
	logic ahb_take;
	lrx_status_t last_status_r;
	logic [2:0] trail_r;
	logic [LRX_LEN_W-1:0] len_r;
	logic [15:0] good_cnt_r;
	logic [15:0] frag_cnt_r;
	lrx_state_t state_r;

	assign ahb_take = hsel & htrans[1] & hready;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end else begin
			wr_pend_r <= ahb_take & hwrite;
			wr_addr_r <= haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r <= LRX_CTRL_RESET;
			station_r <= LRX_ADDR_RESET;
		end else if (wr_pend_r) begin
			case (wr_addr_r)
				LRX_OFS_CTRL: ctrl_r <= hwdata[2:0];
				LRX_OFS_ADDR_LO: station_r[31:0] <= hwdata;
				LRX_OFS_ADDR_HI: station_r[47:32] <= hwdata[15:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (haddr[7:0])
			LRX_OFS_CTRL: rd_mux[2:0] = ctrl_r;
			LRX_OFS_ADDR_LO: rd_mux = station_r[31:0];
			LRX_OFS_ADDR_HI: rd_mux[15:0] = station_r[47:32];
			LRX_OFS_STATUS: begin
				rd_mux[LRX_STAT_CODE_LSB +: 2] = last_status_r;
				rd_mux[LRX_STAT_TRAIL_LSB +: 3] = trail_r;
				rd_mux[LRX_STAT_ACTIVE] = (state_r == LRX_ST_RECV);
				rd_mux[LRX_STAT_CARRIER] = phy_s2_r.carrier_present;
				rd_mux[LRX_STAT_CONTENTION] = phy_s2_r.contention_flag;
			end
			LRX_OFS_LENGTH: rd_mux[LRX_LEN_W-1:0] = len_r;
			LRX_OFS_COUNT: rd_mux = {frag_cnt_r, good_cnt_r};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data is latched at the address phase so it stands from a flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) hrdata_r <= 32'h0000_0000;
		else if (ahb_take && !hwrite) hrdata_r <= rd_mux;
	end

	// ------------------------------------------------------------
	// Receive sequencer
	// ------------------------------------------------------------
	logic [LRX_LEN_W-1:0] bit_position_r;
	logic take_bit;
	logic octet_done;
	logic [7:0] new_octet;
	logic [12:0] octet_idx;
	logic [7:0] octet_sr_r;
	logic [LRX_LEN_W-1:0] len_trunc;
	logic [LRX_LEN_W-1:0] slot_len;
	logic fragment;

	// Receive only: this block never transmits, so no own-frame loopback
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) state_r <= LRX_ST_INIT;
		else begin
			case (state_r)
				LRX_ST_INIT: begin
					if (!phy_s2_r.carrier_present && ctrl_r[LRX_CTRL_ENABLE])
						state_r <= LRX_ST_ARM;
				end
				LRX_ST_ARM: state_r <= LRX_ST_RECV;
				LRX_ST_RECV: begin
					if (bit_tick && !phy_s2_r.carrier_present)
						state_r <= LRX_ST_LEN;
				end
				LRX_ST_LEN: state_r <= ctrl_r[LRX_CTRL_ENABLE] ? LRX_ST_ARM : LRX_ST_INIT;
				default: state_r <= LRX_ST_INIT;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Serial bit collector and check code
	// ------------------------------------------------------------
	logic [31:0] crc_r;
	logic [31:0] crc_oct_r;
	logic [31:0] crc_nxt;

	assign take_bit = (state_r == LRX_ST_RECV) & bit_tick & phy_s2_r.carrier_present;
	assign octet_done = take_bit & (bit_position_r[2:0] == 3'h7);
	assign new_octet = {phy_s2_r.rx_data, octet_sr_r[7:1]};
	assign octet_idx = bit_position_r[LRX_LEN_W-1:3];
	assign crc_nxt = lrx_crc_step(crc_r, phy_s2_r.rx_data);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bit_position_r <= '0;
			octet_sr_r <= 8'h00;
			crc_r <= LRX_CRC_INIT;
			crc_oct_r <= LRX_CRC_INIT;
		end else if (state_r == LRX_ST_ARM) begin
			bit_position_r <= '0;
			crc_r <= LRX_CRC_INIT;
			crc_oct_r <= LRX_CRC_INIT;
		end else if (take_bit) begin
			octet_sr_r <= new_octet;
			bit_position_r <= bit_position_r + 1'b1;
			crc_r <= crc_nxt;
			// Trailing bits never reach the octet-boundary snapshot
			if (bit_position_r[2:0] == 3'h7)
				crc_oct_r <= crc_nxt;
		end
	end

	// ------------------------------------------------------------
	// Destination filter
	// ------------------------------------------------------------
	logic st_match_r;
	logic bc_match_r;
	logic accepted_r;
	logic [39:0] dest_r;
	logic octet_eq;
	logic recognized;

	assign octet_eq = (new_octet == station_r[{octet_idx[2:0], 3'b000} +: 8]);
	assign recognized = ctrl_r[LRX_CTRL_PROMISC] | (st_match_r & octet_eq)
		| (bc_match_r & (new_octet == LRX_BCAST_OCTET) & ctrl_r[LRX_CTRL_BCAST]);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_match_r <= 1'b1;
			bc_match_r <= 1'b1;
			accepted_r <= 1'b0;
			dest_r <= 40'h00_0000_0000;
		end else if (state_r == LRX_ST_ARM) begin
			st_match_r <= 1'b1;
			bc_match_r <= 1'b1;
			accepted_r <= 1'b0;
		end else if (octet_done && octet_idx <= LRX_DEST_LAST_OCTET) begin
			st_match_r <= st_match_r & octet_eq;
			bc_match_r <= bc_match_r & (new_octet == LRX_BCAST_OCTET);
			if (octet_idx != LRX_DEST_LAST_OCTET)
				dest_r[{octet_idx[2:0], 3'b000} +: 8] <= new_octet;
			else
				accepted_r <= recognized;
		end
	end

	// ------------------------------------------------------------
	// Length processing and client stream
	// ------------------------------------------------------------
	lrx_status_t verdict;

	assign len_trunc = {bit_position_r[LRX_LEN_W-1:3], 3'b000};
	assign slot_len = LRX_LEN_W'(SLOT_BITS);
	assign fragment = (len_trunc < slot_len);

	always_comb begin
		if (crc_oct_r == LRX_CRC_RESIDUE) verdict = LRX_STATUS_GOOD;
		else if (bit_position_r[2:0] == 3'h0) verdict = LRX_STATUS_CHECKSUM_FAIL;
		else verdict = LRX_STATUS_MISALIGNED;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			client_rx <= '0;
		end else begin
			client_rx.hdr_valid <= octet_done && octet_idx == LRX_DEST_LAST_OCTET
				&& recognized;
			client_rx.octet_valid <= octet_done && octet_idx > LRX_DEST_LAST_OCTET
				&& accepted_r;
			client_rx.done <= (state_r == LRX_ST_LEN) && !fragment && accepted_r;
			// A fragment already announced by header is withdrawn, nothing more
			client_rx.cancel <= (state_r == LRX_ST_LEN) && fragment && accepted_r;
			if (octet_done && octet_idx == LRX_DEST_LAST_OCTET)
				client_rx.dest <= {new_octet, dest_r};
			if (octet_done)
				client_rx.octet <= new_octet;
			if (state_r == LRX_ST_LEN) begin
				client_rx.status <= verdict;
				client_rx.trailing <= bit_position_r[2:0];
				client_rx.length <= len_trunc;
			end
		end
	end

	// Last outcome and counters for software
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_status_r <= LRX_STATUS_GOOD;
			trail_r <= 3'h0;
			len_r <= '0;
			good_cnt_r <= 16'h0000;
			frag_cnt_r <= 16'h0000;
		end else if (state_r == LRX_ST_LEN) begin
			trail_r <= bit_position_r[2:0];
			len_r <= len_trunc;
			if (fragment && bit_position_r != '0)
				frag_cnt_r <= frag_cnt_r + 1'b1;
			if (!fragment && accepted_r) begin
				last_status_r <= verdict;
				if (verdict == LRX_STATUS_GOOD)
					good_cnt_r <= good_cnt_r + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_arm_resets_position: assert property ((state_r == LRX_ST_ARM)
		|=> (bit_position_r == '0) && (state_r == LRX_ST_RECV))
		else $error("Arm did not clear bit position");
	a_bit_advances_once: assert property (take_bit
		|=> bit_position_r == LRX_LEN_W'($past(bit_position_r) + 1'b1))
		else $error("Bit position did not advance by one");
	a_no_carrier_holds: assert property ((state_r == LRX_ST_RECV) && !take_bit
		|=> $stable(bit_position_r))
		else $error("Bit position moved without a carried bit");
	a_carrier_drop_ends: assert property ((state_r == LRX_ST_RECV) && bit_tick
		&& !phy_s2_r.carrier_present |=> (state_r == LRX_ST_LEN) ##1 (state_r != LRX_ST_LEN))
		else $error("Reception did not end on carrier loss");
	a_init_waits_idle: assert property ((state_r == LRX_ST_INIT)
		&& phy_s2_r.carrier_present |=> (state_r == LRX_ST_INIT))
		else $error("Receive started while carrier present");
	a_trailing_mod_eight: assert property ((state_r == LRX_ST_LEN)
		|=> (trail_r == $past(bit_position_r[2:0])) && (len_r[2:0] == 3'h0))
		else $error("Trailing count or truncated length wrong");
	a_fragment_silent: assert property ((state_r == LRX_ST_LEN) && fragment
		|=> !client_rx.done)
		else $error("Fragment reported as completed frame");
	a_filter_gates_data: assert property (client_rx.octet_valid |-> accepted_r)
		else $error("Octet passed for unrecognized destination");
	a_good_on_residue: assert property ((state_r == LRX_ST_LEN) && !fragment && accepted_r
		&& (crc_oct_r == LRX_CRC_RESIDUE) |=> client_rx.done
		&& (client_rx.status == LRX_STATUS_GOOD))
		else $error("Matching check code not reported good");
	a_mismatch_kind: assert property ((state_r == LRX_ST_LEN) && !fragment && accepted_r
		&& (crc_oct_r != LRX_CRC_RESIDUE) |=> client_rx.status
		== ((client_rx.trailing == 3'h0) ? LRX_STATUS_CHECKSUM_FAIL : LRX_STATUS_MISALIGNED))
		else $error("Mismatch classified wrongly");
	a_done_needs_both: assert property (client_rx.done |-> $past(state_r == LRX_ST_LEN)
		&& $past(accepted_r) && ($past(len_trunc) >= slot_len))
		else $error("Completion without length and filter pass");
	a_three_statuses: assert property (client_rx.done
		|-> (client_rx.status != 2'b11) && (last_status_r == client_rx.status))
		else $error("Undefined receive status");

	c_good_frame: cover property (client_rx.done && client_rx.status == LRX_STATUS_GOOD);
	c_checksum_fail: cover property (client_rx.done
		&& client_rx.status == LRX_STATUS_CHECKSUM_FAIL);
	c_misaligned: cover property (client_rx.done && client_rx.status == LRX_STATUS_MISALIGNED);
	c_fragment_cancel: cover property (client_rx.cancel);

endmodule // lrx_frame_receive_link

/* verification/lrx_phy_model.sv */
// Behavioural physical channel that feeds serial frames to the receive link
`timescale 1ns/1ns
module lrx_phy_model
	import lrx_pkg::*;
#(
	parameter int HALF_NS = 32
) (
	// Channel pins toward the receiver
	output lrx_phy_rx_t phy_out
);
	// No local transmitter, so contention stays low
	initial phy_out = '0;

	// Preamble already stripped: the first bit sent is frame bit one
	task automatic send_bits(input logic bits[$]);
		// No cable delay modelled, so the round trip stays far inside its budget
		phy_out.carrier_present = 1'b1;
		#(HALF_NS);
		foreach (bits[i]) begin
			phy_out.rx_data = bits[i];
			#(HALF_NS) phy_out.rx_clk = 1'b1;
			#(HALF_NS) phy_out.rx_clk = 1'b0;
		end
		// Carrier drops, one closing edge, then the clock stands still
		phy_out.carrier_present = 1'b0;
		phy_out.rx_data = ~phy_out.rx_data;
		#(HALF_NS) phy_out.rx_clk = 1'b1;
		#(HALF_NS) phy_out.rx_clk = 1'b0;
	endtask
endmodule // lrx_phy_model

/* verification/lrx_frame_receive_link_bench.sv */
// Self-checking bench for the frame receive link
`timescale 1ns/1ns
module lrx_frame_receive_link_bench;
	import lrx_pkg::*;
	localparam int SLOT = 64;
	// {ctrl, broadcast dest, accepted}
	// Last mode disables the receiver, yet the attempt already armed still completes
	localparam logic [4:0] MODES [5] = '{5'h17, 5'h06, 5'h0D, 5'h04, 5'h01};
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	wire logic hready;
	logic [31:0] hrdata;
	logic hresp;
	lrx_phy_rx_t phy_in;
	lrx_client_rx_t client_rx;
	logic [63:0] notes[$];
	logic [47:0] station;
	int errors = 0;
	int samples_checked = 0;

	lrx_frame_receive_link #(
		.SLOT_BITS(SLOT)
	) uut (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hrdata(hrdata),
		.hreadyout(hready),
		.hresp(hresp),
		.phy_in(phy_in),
		.client_rx(client_rx)
	);

	lrx_phy_model phy (
		.phy_out(phy_in)
	);

	initial forever #4 hclk = ~hclk;

	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Oldest note must match each client event
	task automatic take(input logic [63:0] seen);
		logic [63:0] exp;
		exp = notes.size() ? notes.pop_front() : 'x;
		check("client event", seen, exp);
	endtask

	always @(posedge hclk) begin
		if (client_rx.hdr_valid === 1'b1) take({4'h1, 12'h000, client_rx.dest});
		if (client_rx.octet_valid === 1'b1) take({4'h2, 52'h0, client_rx.octet});
		if (client_rx.done === 1'b1) begin
			take({4'h3, 39'h0, client_rx.status, client_rx.trailing, client_rx.length});
		end
		if (client_rx.cancel === 1'b1) take({4'h4, 60'h0});
	end

	// ----------------------------------------
	// Drivers
	// ----------------------------------------
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		bus(1'b0, a, 32'h0000_0000, v);
		check("register", v, exp);
	endtask

	function automatic logic [31:0] crc_bit(input logic [31:0] c, input logic b);
		return (c[0] ^ b) ? ((c >> 1) ^ LRX_CRC_POLY) : (c >> 1);
	endfunction

	// Builds a frame, notes what the client must see, hands bits to the channel
	task automatic frame(input logic [47:0] d, input int npay, input int nsend, input int extra,
			input logic bad, input logic acc);
		logic [7:0] oct[$];
		logic bits[$];
		logic [31:0] c;
		int len;
		c = LRX_CRC_INIT;
		for (int i = 0; i < 6; i++) oct.push_back(d[8*i +: 8]);
		repeat (npay) oct.push_back(8'($urandom));
		foreach (oct[i]) for (int j = 0; j < 8; j++) c = crc_bit(c, oct[i][j]);
		for (int i = 0; i < 4; i++) oct.push_back(~c[8*i +: 8] ^ {7'h00, bad});
		if (nsend > 0) oct = oct[0:nsend-1];
		len = 8 * oct.size();
		foreach (oct[i]) for (int j = 0; j < 8; j++) bits.push_back(oct[i][j]);
		repeat (extra) bits.push_back(1'($urandom));
		if (acc && len >= 48) begin
			notes.push_back({4'h1, 12'h000, d});
			for (int i = 6; i < oct.size(); i++) notes.push_back({4'h2, 52'h0, oct[i]});
			if (len >= SLOT) begin
				notes.push_back({4'h3, 39'h0, bad ? (extra != 0 ? LRX_STATUS_MISALIGNED :
					LRX_STATUS_CHECKSUM_FAIL) : LRX_STATUS_GOOD, 3'(extra), 16'(len)});
			end else begin
				notes.push_back({4'h4, 60'h0});
			end
		end
		phy.send_bits(bits);
		#200;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		logic [31:0] v;
		logic [47:0] d;
		void'($urandom(56624));
		station = 48'({$urandom, $urandom});
		station[0] = 1'b0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		reg_chk(LRX_OFS_CTRL, 32'(LRX_CTRL_RESET));
		reg_chk(LRX_OFS_ADDR_LO, 32'h0000_0000);
		reg_chk(8'h20, 32'h0000_0000);
		bus(1'b1, LRX_OFS_LENGTH, 32'hFFFF_FFFF, v);
		reg_chk(LRX_OFS_LENGTH, 32'h0000_0000);
		bus(1'b1, LRX_OFS_ADDR_LO, station[31:0], v);
		bus(1'b1, LRX_OFS_ADDR_HI, {16'h0000, station[47:32]}, v);
		reg_chk(LRX_OFS_ADDR_HI, {16'h0000, station[47:32]});
		$display("test registers done");
		frame(station, 2, 0, 0, 1'b0, 1'b1);
		frame(station, 3, 0, 0, 1'b1, 1'b1);
		frame(station, 2, 0, 3, 1'b1, 1'b1);
		frame(station, 2, 0, 5, 1'b0, 1'b1);
		frame(station ^ 48'h0001_0000_0000, 2, 0, 0, 1'b0, 1'b0);
		frame(station, 0, 7, 7, 1'b0, 1'b1);
		frame(station, 0, 4, 0, 1'b0, 1'b1);
		frame(station, 0, 8, 0, 1'b1, 1'b1);
		$display("test frames done");
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, LRX_OFS_CTRL, {29'h0, MODES[i][4:2]}, v);
			d = MODES[i][1] ? 48'hFFFF_FFFF_FFFF :
				(MODES[i][4:2] == 3'h0 ? station : station ^ 48'h0001_0000_0000);
			frame(d, 1, 0, 0, 1'b0, MODES[i][0]);
		end
		// Disabled and idle: this frame must leave no trace
		frame(station, 1, 0, 0, 1'b0, 1'b0);
		bus(1'b1, LRX_OFS_CTRL, 32'(LRX_CTRL_RESET), v);
		frame(station, 2, 0, 0, 1'b0, 1'b1);
		$display("test filter modes done");
		repeat (100) @(posedge hclk);
		check("pending notes", 64'(notes.size()), 64'h0);
		bus(1'b0, LRX_OFS_COUNT, 32'h0000_0000, v);
		check("fragment count", 64'(v[31:16]), 64'h2);
		check("good count", 64'(v[15:0]), 64'h6);
		bus(1'b0, LRX_OFS_STATUS, 32'h0000_0000, v);
		check("last status", 64'(v[1:0]), 64'(LRX_STATUS_GOOD));
		check("receiving", 64'(v[LRX_STAT_ACTIVE]), 64'h1);
		reg_chk(LRX_OFS_LENGTH, 32'h0000_0060);
		$display("test totals done");
		tally_and_finish();
	end

	initial begin
		#400_000;
		errors++;
		tally_and_finish();
	end
endmodule // lrx_frame_receive_link_bench
